// ---- hcie_events.sv ----
/*
  Interrupt event, enable and channel receive mask registers of a serial
  bus host controller, reached over an AHB-Lite slave port.
  Assumes every event source is driven by logic on hclk, the only slave on
  its bus (hreadyout is the bus hready) and single word transfers only.
*/
// Implementation choice: the AHB-Lite interface to the registers.
// Overview of operation
// - each low channel mask bit one enables reception on that channel.
// - event bit sets on source rising edge or software write-one at set.
// - event bit clears only by write-one at clear address; bit 16 also by bus reinit.
// - set address reads raw events; clear address reads events AND enables.
// - both enable addresses read enables; write-one sets or clears them.
// - gate bit 31 zero blocks interrupt; does not alter masked read.
// - bit 30 flags memory read done; software should keep it cleared.
// - bit 29 is software only, enabled by enable bit 29.
// - bit 27 sets on late-ack conditions while late-ack allowed.
// - bit 26 sets when a phy register byte arrives.
// - as timing root, overlong cycle sets bit 25 and drops root role.
// - bit 24 sets on fatal halt; blocks context events while set.
// - bit 23 sets when received cycle start mismatches local timer.
// - bit 22 flags a missed period, possibly predicted.
// - bit 21 sets whenever seconds counter bit six changes.
// - bit 20 sets when the cycle count low bit toggles.
// - bit 19 phy interrupt request; bit 18 register access fault.
// - bit 17 on bus reinit; bit 16 on ident end, cleared by 17.
// - bit 15 sets with bit 16 and survives bus reinit.
// - bit 9 atomic reply fault; bit 8 buffered write fault.
// - bits 7 and 6 are unlatched read-only summaries.
// - bits 5..0 set on packet stored and dma command completion.
`timescale 1ns/1ns
`default_nettype none
`include "hcie_defines.svh"

module hcie_events (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        nvm_read_done,
  input  wire logic        host_fifo_pending,
  input  wire logic        phys_resp_busy,
  input  wire logic        late_ack_sent,
  input  wire logic        phy_byte_arrived,
  input  wire logic        overlong_cycle,
  input  wire logic        fatal_halt,
  input  wire logic        rx_cycle_start,
  input  wire logic [6:0]  rx_timer_secs,
  input  wire logic [12:0] rx_timer_tick,
  input  wire logic [31:0] cycle_timer,
  input  wire logic        missed_period,
  input  wire logic        phy_irq_request,
  input  wire logic        csr_access_fault,
  input  wire logic        link_reinit_seen,
  input  wire logic        ident_stream_done,
  input  wire logic        atomic_reply_fault,
  input  wire logic        buffered_write_fault,
  input  wire logic        periodic_rx_summary,
  input  wire logic        periodic_tx_summary,
  input  wire logic        reply_pkt_stored,
  input  wire logic        request_pkt_stored,
  input  wire logic        rx_reply_dma_done,
  input  wire logic        rx_request_dma_done,
  input  wire logic        tx_reply_dma_done,
  input  wire logic        tx_request_dma_done,
  output logic [31:0]      rx_channel_mask_low,
  output logic             late_ack_allow,
  output logic             timing_root_role,
  output logic             irq
);

  hcie_pkg::hcie_state_t st_reg;
  hcie_pkg::hcie_state_t st_next;

  logic        take;
  logic [31:0] src_now;
  logic [31:0] rise;
  logic [31:0] hw_set;
  logic        timer_mismatch;
  logic        wr_cycle;
  logic [31:0] sw_set_ev;
  logic [31:0] sw_clr_ev;
  logic [31:0] sw_set_ena;
  logic [31:0] sw_clr_ena;
  logic [31:0] masked_ev;
  logic [31:0] raw_ev;

  // outputs straight from the state flops, except hresp tied low
  assign hreadyout           = st_reg.hreadyout;
  assign hresp               = 1'h0;
  assign hrdata              = st_reg.hrdata;
  assign rx_channel_mask_low = st_reg.rx_channel_mask_low;
  assign late_ack_allow      = st_reg.late_ack_allow;
  assign timing_root_role    = st_reg.timing_root_role;
  assign irq                 = st_reg.irq;

  // address phase accepted only on a real transfer with the bus ready
  assign take     = hsel && htrans[1] && hready;
  assign wr_cycle = (st_reg.bus_st == hcie_pkg::HCIE_ST_ACC) && st_reg.acc_write;

  // software write strobes, applied in the single data-phase cycle
  assign sw_set_ev  = (wr_cycle && st_reg.acc_addr == `HCIE_OFS_EVT_SET) ?
                      (hwdata & `HCIE_EVT_WMASK) : `HCIE_RST_WORD;
  assign sw_clr_ev  = (wr_cycle && st_reg.acc_addr == `HCIE_OFS_EVT_CLR) ?
                      (hwdata & `HCIE_EVT_WMASK) : `HCIE_RST_WORD;
  assign sw_set_ena = (wr_cycle && st_reg.acc_addr == `HCIE_OFS_ENA_SET) ?
                      (hwdata & `HCIE_ENA_WMASK) : `HCIE_RST_WORD;
  assign sw_clr_ena = (wr_cycle && st_reg.acc_addr == `HCIE_OFS_ENA_CLR) ?
                      (hwdata & `HCIE_ENA_WMASK) : `HCIE_RST_WORD;

  // timer compare
  // seconds sit in timer bits 31:25, count in 24:12
  assign timer_mismatch = rx_cycle_start &&
                          ((rx_timer_secs != cycle_timer[31:25]) ||
                           (rx_timer_tick != cycle_timer[24:12]));

  // unlatched summaries
  // the per-context AND/OR happens upstream; only read here
  assign raw_ev    = st_reg.event_flags |
                     ({31'h0000_0000, periodic_rx_summary} << `HCIE_B_PRX) |
                     ({31'h0000_0000, periodic_tx_summary} << `HCIE_B_PTX);
  assign masked_ev = raw_ev & st_reg.event_enable & ~(32'h0000_0001 << `HCIE_B_GATE);

  // level sources gathered by bit position; edges taken below
  always_comb begin
    src_now = `HCIE_RST_WORD;
    src_now[`HCIE_B_NVM]      = nvm_read_done;
    src_now[`HCIE_B_TARDY]    = st_reg.late_ack_allow &&
                                (host_fifo_pending || phys_resp_busy || late_ack_sent);
    src_now[`HCIE_B_PHYBYTE]  = phy_byte_arrived;
    src_now[`HCIE_B_OVERLONG] = overlong_cycle && st_reg.timing_root_role;
    src_now[`HCIE_B_HALT]     = fatal_halt;
    src_now[`HCIE_B_MISMATCH] = timer_mismatch;
    src_now[`HCIE_B_MISSED]   = missed_period;
    src_now[`HCIE_B_PHYIRQ]   = phy_irq_request;
    src_now[`HCIE_B_CSRFAULT] = csr_access_fault;
    src_now[`HCIE_B_REINIT]   = link_reinit_seen;
    src_now[`HCIE_B_IDENT]    = ident_stream_done;
    src_now[`HCIE_B_ATOMIC]   = atomic_reply_fault;
    src_now[`HCIE_B_BUFWR]    = buffered_write_fault;
    src_now[5]                = reply_pkt_stored;
    src_now[4]                = request_pkt_stored;
    src_now[3]                = rx_reply_dma_done;
    src_now[2]                = rx_request_dma_done;
    src_now[1]                = tx_reply_dma_done;
    src_now[0]                = tx_request_dma_done;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_edge
      assign rise[gi] = src_now[gi] && !st_reg.src_prev[gi];
    end
  endgenerate

  // hardware set vector: edges, timer flips and the blocking during halt
  always_comb begin
    hw_set = rise & `HCIE_EVT_WMASK;
    hw_set[`HCIE_B_SOFT]   = 1'h0;
    hw_set[`HCIE_B_IDENT2] = rise[`HCIE_B_IDENT];
    hw_set[`HCIE_B_SECS6]  = cycle_timer[`HCIE_T_SECS6] != st_reg.secs6_prev;
    hw_set[`HCIE_B_PERIOD] = cycle_timer[`HCIE_T_TICK0] != st_reg.tick0_prev;
    // block context events
    // the halted contexts are not identified here, so all are held off
    if (st_reg.event_flags[`HCIE_B_HALT]) begin
      hw_set = hw_set & ~`HCIE_HALT_BLOCK;
    end
  end

  // next state: bus slave, registers and interrupt
  always_comb begin
    st_next = st_reg;
    st_next.src_prev   = src_now;
    st_next.secs6_prev = cycle_timer[`HCIE_T_SECS6];
    st_next.tick0_prev = cycle_timer[`HCIE_T_TICK0];

    // set, clear
    // a set in the same cycle wins over the clear, so no event is lost
    st_next.event_flags = ((st_reg.event_flags & ~sw_clr_ev) | sw_set_ev | hw_set)
                          & `HCIE_EVT_WMASK;
    if (rise[`HCIE_B_REINIT]) begin
      st_next.event_flags[`HCIE_B_IDENT] = 1'h0;
    end

    st_next.event_enable = ((st_reg.event_enable | sw_set_ena) & ~sw_clr_ena)
                           & `HCIE_ENA_WMASK;

    if (wr_cycle && st_reg.acc_addr == `HCIE_OFS_CHAN_SET) begin
      st_next.rx_channel_mask_low = st_reg.rx_channel_mask_low | hwdata;
    end else if (wr_cycle && st_reg.acc_addr == `HCIE_OFS_CHAN_CLR) begin
      st_next.rx_channel_mask_low = st_reg.rx_channel_mask_low & ~hwdata;
    end

    // control word: late-ack allow and timing root role
    if (wr_cycle && st_reg.acc_addr == `HCIE_OFS_CTRL) begin
      st_next.late_ack_allow   = hwdata[`HCIE_CTRL_B_TARDY];
      st_next.timing_root_role = hwdata[`HCIE_CTRL_B_ROLE];
    end
    // overlong drops root role
    // hardware drop wins over a write in the same cycle
    if (rise[`HCIE_B_OVERLONG]) begin
      st_next.timing_root_role = 1'h0;
    end

    st_next.irq = st_reg.event_enable[`HCIE_B_GATE] && (|masked_ev);

    // bus slave: one wait state so writes land before the next access
    case (st_reg.bus_st)
      hcie_pkg::HCIE_ST_IDLE: begin
        st_next.hreadyout = 1'h1;
        if (take) begin
          st_next.bus_st    = hcie_pkg::HCIE_ST_ACC;
          st_next.hreadyout = 1'h0;
          st_next.acc_addr  = haddr[7:0] & 8'hFC;
          st_next.acc_write = hwrite;
        end
      end
      hcie_pkg::HCIE_ST_ACC: begin
        st_next.bus_st    = hcie_pkg::HCIE_ST_IDLE;
        st_next.hreadyout = 1'h1;
        if (!st_reg.acc_write) begin
          case (st_reg.acc_addr)
            `HCIE_OFS_CHAN_SET: st_next.hrdata = st_reg.rx_channel_mask_low;
            `HCIE_OFS_CHAN_CLR: st_next.hrdata = st_reg.rx_channel_mask_low;
            `HCIE_OFS_EVT_SET:  st_next.hrdata = raw_ev;
            `HCIE_OFS_EVT_CLR:  st_next.hrdata = masked_ev;
            `HCIE_OFS_ENA_SET:  st_next.hrdata = st_reg.event_enable;
            `HCIE_OFS_ENA_CLR:  st_next.hrdata = st_reg.event_enable;
            `HCIE_OFS_CTRL:     st_next.hrdata = {30'h0000_0000,
                                                  st_reg.timing_root_role,
                                                  st_reg.late_ack_allow};
            default:            st_next.hrdata = `HCIE_RST_WORD;
          endcase
        end
      end
      default: begin
        st_next.bus_st    = hcie_pkg::HCIE_ST_IDLE;
        st_next.hreadyout = 1'h1;
      end
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.bus_st              <= hcie_pkg::HCIE_ST_IDLE;
      st_reg.hreadyout           <= 1'h1;
      st_reg.hrdata              <= `HCIE_RST_WORD;
      st_reg.acc_addr            <= 8'h00;
      st_reg.acc_write           <= `HCIE_RST_BIT;
      st_reg.event_flags         <= `HCIE_RST_WORD;
      st_reg.event_enable        <= `HCIE_RST_WORD;
      st_reg.rx_channel_mask_low <= `HCIE_RST_WORD;
      st_reg.late_ack_allow      <= `HCIE_RST_BIT;
      st_reg.timing_root_role    <= `HCIE_RST_BIT;
      st_reg.src_prev            <= `HCIE_RST_WORD;
      st_reg.secs6_prev          <= `HCIE_RST_BIT;
      st_reg.tick0_prev          <= `HCIE_RST_BIT;
      st_reg.irq                 <= `HCIE_RST_BIT;
    end else begin
      st_reg <= st_next;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_evt_clr;
    take && !hwrite && (haddr[7:0] == `HCIE_OFS_EVT_CLR) ##1
      (st_reg.bus_st == hcie_pkg::HCIE_ST_ACC);
  endsequence

  sequence s_reinit_edge;
    $rose(link_reinit_seen) && st_reg.src_prev[`HCIE_B_REINIT] == 1'h0;
  endsequence

  AST_GATE_BLOCKS: assert property (
    !st_reg.event_enable[`HCIE_B_GATE] |=> !irq)
    else $error("interrupt raised with gate bit clear");

  AST_IRQ_RAISED: assert property (
    (st_reg.event_enable[`HCIE_B_GATE] && (|masked_ev)) |=> irq)
    else $error("enabled event did not raise interrupt");

  AST_EDGE_SETS: assert property (
    $rose(phy_byte_arrived) |=> st_reg.event_flags[`HCIE_B_PHYBYTE])
    else $error("phy byte edge did not set its event");

  AST_STICKY: assert property (
    (st_reg.event_flags[`HCIE_B_PHYBYTE] && !sw_clr_ev[`HCIE_B_PHYBYTE])
      |=> st_reg.event_flags[`HCIE_B_PHYBYTE])
    else $error("event bit cleared without software clear");

  AST_REINIT: assert property (
    s_reinit_edge |=> st_reg.event_flags[`HCIE_B_REINIT] &&
                      !st_reg.event_flags[`HCIE_B_IDENT])
    else $error("bus reinit did not set 17 and drop 16");

  AST_IDENT_PAIR: assert property (
    ($rose(ident_stream_done) && !$rose(link_reinit_seen)) |=>
      st_reg.event_flags[`HCIE_B_IDENT] && st_reg.event_flags[`HCIE_B_IDENT2])
    else $error("ident end did not set both bits");

  AST_OVERLONG: assert property (
    (st_reg.timing_root_role && $rose(overlong_cycle)) |=>
      !timing_root_role && st_reg.event_flags[`HCIE_B_OVERLONG])
    else $error("overlong cycle not handled");

  AST_SOFT_ONLY: assert property (
    $rose(st_reg.event_flags[`HCIE_B_SOFT]) |-> $past(sw_set_ev[`HCIE_B_SOFT]))
    else $error("software event set without a write");

  AST_HALT_BLOCK: assert property (
    (st_reg.event_flags[`HCIE_B_HALT] && !st_reg.event_flags[0] && !sw_set_ev[0])
      |=> !st_reg.event_flags[0])
    else $error("context event set during halt");

  AST_MASKED_READ: assert property (
    s_read_evt_clr |=> hreadyout && (hrdata == $past(masked_ev)))
    else $error("masked event read wrong");

  // write address phase, then its data phase cycle
  sequence s_chan_set_wr;
    take && hwrite && (haddr[7:0] == `HCIE_OFS_CHAN_SET) ##1 wr_cycle;
  endsequence

  sequence s_chan_clr_wr;
    take && hwrite && (haddr[7:0] == `HCIE_OFS_CHAN_CLR) ##1 wr_cycle;
  endsequence

  AST_CHAN_SET: assert property (
    s_chan_set_wr |=> ((rx_channel_mask_low & $past(hwdata)) == $past(hwdata)))
    else $error("channel mask set write lost");

  AST_CHAN_CLR: assert property (
    s_chan_clr_wr |=> ((rx_channel_mask_low & $past(hwdata)) == 32'h0000_0000))
    else $error("channel mask clear write lost");

  AST_LATE_ACK: assert property (
    (!st_reg.late_ack_allow && !sw_set_ev[`HCIE_B_TARDY] &&
     !st_reg.event_flags[`HCIE_B_TARDY]) |=> !st_reg.event_flags[`HCIE_B_TARDY])
    else $error("late-ack event set while not allowed");

  AST_MISMATCH: assert property (
    (timer_mismatch && !st_reg.src_prev[`HCIE_B_MISMATCH])
      |=> st_reg.event_flags[`HCIE_B_MISMATCH])
    else $error("cycle start mismatch not flagged");

  AST_SECS6: assert property (
    $changed(cycle_timer[`HCIE_T_SECS6]) |=> st_reg.event_flags[`HCIE_B_SECS6])
    else $error("seconds bit six change not flagged");

endmodule : hcie_events
`default_nettype wire

// ---- hcie_defines.svh ----
/*
  Register offsets, field positions, bit masks and reset values of the
  host controller interrupt event block.
  Assumes it is included by its bare name from the design module and the
  testbench.
*/
`ifndef HCIE_DEFINES_SVH
`define HCIE_DEFINES_SVH

// byte offsets on the register bus
`define HCIE_OFS_CHAN_SET     8'h78
`define HCIE_OFS_CHAN_CLR     8'h7C
`define HCIE_OFS_EVT_SET      8'h80
`define HCIE_OFS_EVT_CLR      8'h84
`define HCIE_OFS_ENA_SET      8'h88
`define HCIE_OFS_ENA_CLR      8'h8C
`define HCIE_OFS_CTRL         8'hF0

// reset values
`define HCIE_RST_WORD         32'h0000_0000
`define HCIE_RST_BIT          1'h0

// event bit positions
`define HCIE_B_GATE           31
`define HCIE_B_NVM            30
`define HCIE_B_SOFT           29
`define HCIE_B_TARDY          27
`define HCIE_B_PHYBYTE        26
`define HCIE_B_OVERLONG       25
`define HCIE_B_HALT           24
`define HCIE_B_MISMATCH       23
`define HCIE_B_MISSED         22
`define HCIE_B_SECS6          21
`define HCIE_B_PERIOD         20
`define HCIE_B_PHYIRQ         19
`define HCIE_B_CSRFAULT       18
`define HCIE_B_REINIT         17
`define HCIE_B_IDENT          16
`define HCIE_B_IDENT2         15
`define HCIE_B_ATOMIC         9
`define HCIE_B_BUFWR          8
`define HCIE_B_PRX            7
`define HCIE_B_PTX            6

// cycle timer field positions
`define HCIE_T_SECS6          31
`define HCIE_T_TICK0          12

// bit masks
`define HCIE_EVT_WMASK        32'h6FFF_833F
`define HCIE_ENA_WMASK        32'hEFFF_83FF
`define HCIE_HALT_BLOCK       32'h0000_003F
`define HCIE_CTRL_B_TARDY     0
`define HCIE_CTRL_B_ROLE      1

`endif

// ---- hcie_pkg.sv ----
/*
  Types of the host controller interrupt event block: bus state and the
  packed state record of the module.
  Assumes nothing beyond the defines header.
*/
package hcie_pkg;

  typedef enum logic [0:0] {
    HCIE_ST_IDLE,
    HCIE_ST_ACC
  } hcie_bus_st_t;

  typedef struct packed {
    hcie_bus_st_t bus_st;
    logic         hreadyout;
    logic [31:0]  hrdata;
    logic [7:0]   acc_addr;
    logic         acc_write;
    logic [31:0]  event_flags;
    logic [31:0]  event_enable;
    logic [31:0]  rx_channel_mask_low;
    logic         late_ack_allow;
    logic         timing_root_role;
    logic [31:0]  src_prev;
    logic         secs6_prev;
    logic         tick0_prev;
    logic         irq;
  } hcie_state_t;

endpackage : hcie_pkg

// ---- hcie_events_tb.sv ----
/*
  Self-checking testbench of the interrupt event block: an AHB-Lite master
  made of tasks, event sources pulsed by hand, one task per scenario.
  Assumes the block is the only slave, so hreadyout is looped to hready.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hcie_defines.svh"

`define CHK(what, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); \
  end \
end

module hcie_events_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] cycle_timer;
  logic [6:0]  rx_timer_secs;
  logic [12:0] rx_timer_tick;
  logic [22:0] src;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] rx_channel_mask_low;
  logic        late_ack_allow;
  logic        timing_root_role;
  logic        irq;
  int          bad_count;
  int          checked;

  // event bit of each plain source src[0..12]
  localparam logic [4:0] PBIT [13] = '{5'h1E, 5'h1A, 5'h16, 5'h13, 5'h12, 5'h09, 5'h08,
                                       5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  hcie_events hcie_events_inst (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .nvm_read_done        (src[0]),
    .host_fifo_pending    (src[16]),
    .phys_resp_busy       (src[17]),
    .late_ack_sent        (src[18]),
    .phy_byte_arrived     (src[1]),
    .overlong_cycle       (src[19]),
    .fatal_halt           (src[13]),
    .rx_cycle_start       (src[20]),
    .rx_timer_secs        (rx_timer_secs),
    .rx_timer_tick        (rx_timer_tick),
    .cycle_timer          (cycle_timer),
    .missed_period        (src[2]),
    .phy_irq_request      (src[3]),
    .csr_access_fault     (src[4]),
    .link_reinit_seen     (src[14]),
    .ident_stream_done    (src[15]),
    .atomic_reply_fault   (src[5]),
    .buffered_write_fault (src[6]),
    .periodic_rx_summary  (src[21]),
    .periodic_tx_summary  (src[22]),
    .reply_pkt_stored     (src[7]),
    .request_pkt_stored   (src[8]),
    .rx_reply_dma_done    (src[9]),
    .rx_request_dma_done  (src[10]),
    .tx_reply_dma_done    (src[11]),
    .tx_request_dma_done  (src[12]),
    .rx_channel_mask_low  (rx_channel_mask_low),
    .late_ack_allow       (late_ack_allow),
    .timing_root_role     (timing_root_role),
    .irq                  (irq)
  );

  // free running 100 MHz clock
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end

  // wait for ready sampled high at an edge; only the watchdog ends a hang
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'h1);
  endtask : wait_rdy

  // one single-word transfer: address phase, then data phase
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd_val);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy;
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd_val = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(a, 1'h1, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    xfer(a, 1'h0, 32'h0000_0000, d);
    `CHK(what, e, d)
  endtask : rd_chk

  // source high for one cycle, then room for the flag and irq to land
  task automatic pulse(input int i);
    @(posedge hclk);
    src[i] <= 1'h1;
    @(posedge hclk);
    src[i] <= 1'h0;
    repeat (3) @(posedge hclk);
  endtask : pulse

  task automatic clr_all;
    wr(`HCIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
  endtask : clr_all

  task automatic t_reset;
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_0000, "events after reset");
    rd_chk(`HCIE_OFS_ENA_SET, 32'h0000_0000, "enables after reset");
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    `CHK("irq after reset", 1'h0, irq)
    `CHK("response code", 1'h0, hresp)
    $display("test reset done");
  endtask : t_reset

  task automatic t_chan;
    wr(`HCIE_OFS_CHAN_SET, 32'hA5A5_0F0F);
    rd_chk(`HCIE_OFS_CHAN_CLR, 32'hA5A5_0F0F, "channel mask");
    wr(`HCIE_OFS_CHAN_CLR, 32'h0000_0F00);
    rd_chk(`HCIE_OFS_CHAN_SET, 32'hA5A5_000F, "channel mask");
    `CHK("channel enables", 32'hA5A5_000F, rx_channel_mask_low)
    $display("test channel mask done");
  endtask : t_chan

  // every plain source: edge sets, zero write keeps, one write clears
  task automatic t_sources;
    for (int i = 0; i < 13; i++) begin
      pulse(i);
      rd_chk(`HCIE_OFS_EVT_SET, 32'h1 << PBIT[i], "source flag");
      wr(`HCIE_OFS_EVT_CLR, 32'h0000_0000);
      rd_chk(`HCIE_OFS_EVT_SET, 32'h1 << PBIT[i], "flag after zero clear");
      wr(`HCIE_OFS_EVT_CLR, 32'h1 << PBIT[i]);
      rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_0000, "flag cleared");
    end
    $display("test sources done");
  endtask : t_sources

  task automatic t_gate;
    wr(`HCIE_OFS_ENA_SET, 32'h2000_0000);
    wr(`HCIE_OFS_EVT_SET, 32'h2000_0000);
    repeat (2) @(negedge hclk);
    `CHK("irq with gate off", 1'h0, irq)
    rd_chk(`HCIE_OFS_EVT_CLR, 32'h2000_0000, "masked events");
    wr(`HCIE_OFS_ENA_SET, 32'h8000_0000);
    repeat (2) @(negedge hclk);
    `CHK("irq with gate on", 1'h1, irq)
    rd_chk(`HCIE_OFS_EVT_CLR, 32'h2000_0000, "masked events gate on");
    rd_chk(`HCIE_OFS_ENA_CLR, 32'hA000_0000, "enables");
    wr(`HCIE_OFS_ENA_CLR, 32'h2000_0000);
    repeat (2) @(negedge hclk);
    `CHK("irq with bit disabled", 1'h0, irq)
    wr(`HCIE_OFS_ENA_CLR, 32'h8000_0000);
    clr_all;
    $display("test gate done");
  endtask : t_gate

  task automatic t_ident;
    pulse(15);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0001_8000, "ident flags");
    pulse(14);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0002_8000, "reinit flags");
    clr_all;
    $display("test ident done");
  endtask : t_ident

  task automatic t_halt;
    pulse(13);
    pulse(7);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0100_0000, "halt blocks context");
    clr_all;
    pulse(7);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_0020, "context after halt");
    clr_all;
    $display("test halt done");
  endtask : t_halt

  task automatic t_ctrl;
    pulse(16);
    pulse(19);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_0000, "disabled late ack");
    wr(`HCIE_OFS_CTRL, 32'h0000_0003);
    `CHK("late ack allow", 1'h1, late_ack_allow)
    rd_chk(`HCIE_OFS_CTRL, 32'h0000_0003, "control word");
    pulse(18);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0800_0000, "late ack flag");
    clr_all;
    pulse(19);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0200_0000, "overlong flag");
    `CHK("root role dropped", 1'h0, timing_root_role)
    rd_chk(`HCIE_OFS_CTRL, 32'h0000_0001, "control after overlong");
    wr(`HCIE_OFS_CTRL, 32'h0000_0000);
    clr_all;
    $display("test control done");
  endtask : t_ctrl

  task automatic t_timer;
    @(posedge hclk);
    cycle_timer <= 32'h0000_1000;
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0010_0000, "tick toggle");
    clr_all;
    @(posedge hclk);
    cycle_timer <= 32'h8000_1000;
    rx_timer_secs <= 7'h40;
    rx_timer_tick <= 13'h0001;
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0020_0000, "seconds bit six");
    clr_all;
    pulse(20);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_0000, "matching cycle start");
    rx_timer_secs <= 7'h41;
    pulse(20);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0080_0000, "mismatching cycle start");
    clr_all;
    $display("test timer done");
  endtask : t_timer

  task automatic t_live;
    @(posedge hclk);
    src[22:21] <= 2'h3;
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_00C0, "live summaries");
    src[22:21] <= 2'h0;
    wr(`HCIE_OFS_EVT_SET, 32'h0000_00C0);
    rd_chk(`HCIE_OFS_EVT_SET, 32'h0000_0000, "summaries not stored");
    $display("test summaries done");
  endtask : t_live

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // main sequence: all inputs known at time zero, reset for two cycles
  initial begin
    bad_count = 0;
    checked = 0;
    hresetn = 1'h0;
    hsel = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    cycle_timer = 32'h0000_0000;
    rx_timer_secs = 7'h00;
    rx_timer_tick = 13'h0000;
    src = 23'h000000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_chan;
    t_sources;
    t_gate;
    t_ident;
    t_halt;
    t_ctrl;
    t_timer;
    t_live;
    conclude;
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    conclude;
  end
endmodule : hcie_events_tb
`default_nettype wire
